/* File: include/swc_pkg.sv */
// constants and types for the standby wake-up source configuration block
// What this block and its software must do
// RULE1: twelve external and eight key inputs may end stop, sleep and idle.
// RULE2: clock and pulse counter interrupts may end only the sleep state.
// RULE3: mode code 00 low, 01 high, 10 falling edge, 11 rising edge.
// RULE4: every mode field resets to 10, falling edge.
// RULE5: enable bit 0 blocks a source, 1 lets it end standby.
// RULE6: one byte per source from the low byte; mode bits 5:4, enable bit 0.
// RULE7: bits 7, 6, 3, 2 and 1 of each byte read zero, writes ignored.
// RULE8: every enable bit resets to 0.
// RULE9: sources four to seven use the same layout in the second register.
// RULE10: software programs a proper mode before enabling a source.
// RULE11: software sets the key wake source to high level before use.
// RULE12: software changes settings only with interrupts disabled.
// RULE13: an enabled source meeting its condition raises a wake request.
// RULE14: a disabled source never causes a wake request.
package swc_pkg;

    // =====================================================================
    // sources
    localparam int unsigned NUM_SRC  = 15;
    localparam int unsigned NUM_SLOT = 16;
    localparam int unsigned SRC_KEY  = 12;
    localparam int unsigned SRC_RTC  = 13;
    localparam int unsigned SRC_QUAD = 14;
    localparam logic [NUM_SLOT-1:0] SLEEP_ONLY_MASK = 16'h6000;
    localparam logic [NUM_SLOT-1:0] SLOT_USED_MASK  = 16'h7fff;

    // =====================================================================
    // register byte addresses
    localparam logic [31:0] WAKE_CFG_SRC0_3_ADDR  = 32'hffffee10;
    localparam logic [31:0] WAKE_CFG_SRC4_7_ADDR  = 32'hffffee14;
    localparam logic [31:0] WAKE_CFG_SRC8_11_ADDR = 32'hffffee18;
    localparam logic [31:0] WAKE_CFG_AUX_ADDR     = 32'hffffee1c;
    localparam logic [31:0] WAKE_HIT_ADDR         = 32'hffffee20;

    // =====================================================================
    // byte lane layout and reset values
    localparam int unsigned LANE_W  = 8;
    localparam int unsigned EN_BIT  = 0;
    localparam int unsigned MODE_LO = 4;
    localparam logic [31:0] CFG_RD_MASK = 32'h31313131;
    localparam logic [1:0]  MODE_RESET  = 2'h2;
    localparam logic        EN_RESET    = 1'h0;
    localparam logic [31:0] RDATA_IDLE  = 32'h00000000;

    // =====================================================================
    // types
    typedef enum logic [1:0] {
        SWC_MODE_LOW  = 2'h0,
        SWC_MODE_HIGH = 2'h1,
        SWC_MODE_FALL = 2'h2,
        SWC_MODE_RISE = 2'h3
    } swc_mode_t;

    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_STOP,
        SWC_SLEEP,
        SWC_IDLE
    } swc_standby_t;

endpackage

/* File: verilog/swc_wake_detect.sv */
// one wake source: input synchroniser, level and edge condition check
`timescale 1ns/1ps
`default_nettype none

module swc_wake_detect
    import swc_pkg::*;
#(
    parameter bit SYNC_IN = 1'b1
)
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      src_in,
    input  wire logic      enable,
    input  wire swc_mode_t mode,
    output logic           hit
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic hit;
    } swc_det_st_t;

    swc_det_st_t st_q;
    swc_det_st_t st_d;
    logic        lvl_new;
    logic        cond;

    // =====================================================================
    // next state
    // pins pass three flops; a change counts once stages two and three agree
    always_comb begin
        st_d    = st_q;
        st_d.s1 = src_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (SYNC_IN) begin
            lvl_new = (st_q.s2 == st_q.s3) ? st_q.s3 : st_q.level;
        end else begin
            lvl_new = src_in;
        end
        st_d.level = lvl_new;
        // edges compare the agreed level against the previous one
        case (mode)
            SWC_MODE_LOW:  cond = !lvl_new;                 // see RULE3
            SWC_MODE_HIGH: cond = lvl_new;                  // see RULE3
            SWC_MODE_FALL: cond = st_q.level && !lvl_new;   // see RULE13
            SWC_MODE_RISE: cond = !st_q.level && lvl_new;   // see RULE13
            default:       cond = 1'b0;
        endcase
        st_d.hit = enable && cond;                          // see RULE14
    end

    // =====================================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hit = st_q.hit;

    // =====================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_high_level: assert property ( // see RULE3
        enable && mode == SWC_MODE_HIGH |=> st_q.hit == st_q.level)
        else $error("high level mode does not follow input level");

    a_rise_edge: assert property ( // see RULE13
        enable && mode == SWC_MODE_RISE |=> st_q.hit == (st_q.level && !$past(st_q.level)))
        else $error("rising edge mode missed or invented an edge");

    a_disabled_off: assert property ( // see RULE14
        !enable |=> !st_q.hit)
        else $error("disabled source produced a hit");

endmodule

`default_nettype wire

/* File: verilog/swc_wake_cfg.sv */
// apb register file and wake request logic for the standby wake sources
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module swc_wake_cfg
    import swc_pkg::*;
#(
    parameter int unsigned NUM_EXT = 12,
    parameter int unsigned NUM_KEY = 8
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [NUM_EXT-1:0] ext_irq,
    input  wire logic [NUM_KEY-1:0] key_wake_input,
    input  wire logic               rtc_wake_irq,
    input  wire logic               quad_counter_wake_irq,
    input  wire swc_standby_t       standby_mode,
    output logic                    wake_request
);

    // =====================================================================
    // parameter checks
    // the register map holds twelve external slots and one shared key slot
    if (NUM_EXT < 1 || NUM_EXT > 12) begin : g_bad_ext
        $error("NUM_EXT must be 1 to 12");
    end
    if (NUM_KEY < 1 || NUM_KEY > 8) begin : g_bad_key
        $error("NUM_KEY must be 1 to 8");
    end

    // =====================================================================
    // state
    typedef struct packed {
        logic [NUM_SLOT-1:0]   en;
        logic [2*NUM_SLOT-1:0] mode;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  wake;
    } swc_st_t;

    swc_st_t st_q;
    swc_st_t st_d;

    logic [NUM_SLOT-1:0] hits;
    logic [NUM_EXT-1:0]  ext_hit;
    logic [NUM_KEY-1:0]  key_hit;
    logic                rtc_hit;
    logic                quad_hit;
    logic                cfg_sel;
    logic                hit_sel;
    logic [1:0]          grp;
    logic [31:0]         rd_val;
    logic [NUM_SLOT-1:0] allow;
    logic                wr_done;
    logic                rd_done;

    // =====================================================================
    // detectors
    // the eight key inputs share one configuration slot
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
            swc_wake_detect #(.SYNC_IN(1'b1)) u_det (
                .pclk    (pclk),
                .presetn (presetn),
                .src_in  (ext_irq[gi]),
                .enable  (st_q.en[gi]),
                .mode    (swc_mode_t'(st_q.mode[2*gi +: 2])),
                .hit     (ext_hit[gi])
            );
        end
        for (gi = 0; gi < NUM_KEY; gi++) begin : g_key
            swc_wake_detect #(.SYNC_IN(1'b1)) u_det (
                .pclk    (pclk),
                .presetn (presetn),
                .src_in  (key_wake_input[gi]),
                .enable  (st_q.en[SRC_KEY]),
                .mode    (swc_mode_t'(st_q.mode[2*SRC_KEY +: 2])),
                .hit     (key_hit[gi])
            );
        end
    endgenerate

    // clock and counter interrupts come from on-chip logic, so no synchroniser
    swc_wake_detect #(.SYNC_IN(1'b0)) u_rtc (
        .pclk    (pclk),
        .presetn (presetn),
        .src_in  (rtc_wake_irq),
        .enable  (st_q.en[SRC_RTC]),
        .mode    (swc_mode_t'(st_q.mode[2*SRC_RTC +: 2])),
        .hit     (rtc_hit)
    );

    swc_wake_detect #(.SYNC_IN(1'b0)) u_quad (
        .pclk    (pclk),
        .presetn (presetn),
        .src_in  (quad_counter_wake_irq),
        .enable  (st_q.en[SRC_QUAD]),
        .mode    (swc_mode_t'(st_q.mode[2*SRC_QUAD +: 2])),
        .hit     (quad_hit)
    );

    // gather hits into the slot map; missing external slots stay quiet
    always_comb begin
        hits = '0;
        for (int i = 0; i < NUM_EXT; i++) begin
            hits[i] = ext_hit[i];
        end
        hits[SRC_KEY]  = |key_hit;
        hits[SRC_RTC]  = rtc_hit;
        hits[SRC_QUAD] = quad_hit;
    end

    // =====================================================================
    // address decode
    always_comb begin
        cfg_sel = 1'b1;
        hit_sel = 1'b0;
        grp     = 2'h0;
        case (paddr)
            WAKE_CFG_SRC0_3_ADDR:  grp = 2'h0;
            WAKE_CFG_SRC4_7_ADDR:  grp = 2'h1;   // see RULE9
            WAKE_CFG_SRC8_11_ADDR: grp = 2'h2;
            WAKE_CFG_AUX_ADDR:     grp = 2'h3;
            WAKE_HIT_ADDR: begin
                cfg_sel = 1'b0;
                hit_sel = 1'b1;
            end
            default: cfg_sel = 1'b0;
        endcase
    end

    // read view: four byte lanes, reserved bits forced to zero
    always_comb begin
        rd_val = RDATA_IDLE;
        if (cfg_sel) begin
            for (int k = 0; k < 4; k++) begin
                rd_val[k*LANE_W + EN_BIT]       = st_q.en[4*grp + k];          // see RULE6
                rd_val[k*LANE_W + MODE_LO +: 2] = st_q.mode[2*(4*grp + k) +: 2]; // see RULE6
            end
            rd_val = rd_val & CFG_RD_MASK;                                     // see RULE7
        end else if (hit_sel) begin
            rd_val[NUM_SLOT-1:0] = hits & SLOT_USED_MASK;
        end
    end

    // =====================================================================
    // standby classes
    // stop and idle ignore the sleep-only sources; running raises nothing
    always_comb begin
        case (standby_mode)
            SWC_STOP:  allow = SLOT_USED_MASK & ~SLEEP_ONLY_MASK;   // see RULE1
            SWC_IDLE:  allow = SLOT_USED_MASK & ~SLEEP_ONLY_MASK;   // see RULE2
            SWC_SLEEP: allow = SLOT_USED_MASK;                      // see RULE2
            default:   allow = '0;
        endcase
    end

    // =====================================================================
    // next state
    // one wait state: pready rises in the second access cycle, so the
    // registered read data and error flag are ready before completion
    assign wr_done = psel && penable && st_q.pready && pwrite;
    assign rd_done = psel && penable && st_q.pready && !pwrite;

    always_comb begin
        st_d         = st_q;
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
        if (psel && penable && !st_q.pready) begin
            st_d.pready  = 1'b1;
            st_d.prdata  = pwrite ? RDATA_IDLE : rd_val;
            st_d.pslverr = !(cfg_sel || hit_sel);
        end
        // writes land only at the completing edge; status is read-only
        if (wr_done && cfg_sel) begin
            for (int k = 0; k < 4; k++) begin
                if (pstrb[k] && SLOT_USED_MASK[4*grp + k]) begin
                    st_d.en[4*grp + k] = pwdata[k*LANE_W + EN_BIT];           // see RULE5
                    st_d.mode[2*(4*grp + k) +: 2] = pwdata[k*LANE_W + MODE_LO +: 2];
                end
            end
        end
        st_d.wake = |(hits & allow);                                       // see RULE13
    end

    // =====================================================================
    // state register
    // modes come up as falling edge and every source disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.en      <= {NUM_SLOT{EN_RESET}};     // see RULE8
            st_q.mode    <= {NUM_SLOT{MODE_RESET}};   // see RULE4
            st_q.prdata  <= RDATA_IDLE;
            st_q.pready  <= 1'b0;
            st_q.pslverr <= 1'b0;
            st_q.wake    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata       = st_q.prdata;
    assign pready       = st_q.pready;
    assign pslverr      = st_q.pslverr;
    assign wake_request = st_q.wake;

    // =====================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_en_reset_zero: assert property ( // see RULE8
        $rose(presetn) |-> st_q.en == '0)
        else $error("enable bits not clear after reset");

    a_mode_reset_fall: assert property ( // see RULE4
        $rose(presetn) |-> st_q.mode == {NUM_SLOT{MODE_RESET}})
        else $error("mode fields not falling edge after reset");

    sequence s_write_a_lane1;
        wr_done && paddr == WAKE_CFG_SRC0_3_ADDR && pstrb[1];
    endsequence

    a_write_lane_a: assert property ( // see RULE5
        s_write_a_lane1 |=> st_q.en[1] == $past(pwdata[8])
            && st_q.mode[3:2] == $past(pwdata[13:12]))
        else $error("write to second lane of first register misplaced");

    sequence s_write_b_lane0;
        wr_done && paddr == WAKE_CFG_SRC4_7_ADDR && pstrb[0];
    endsequence

    a_write_grp_b: assert property ( // see RULE9
        s_write_b_lane0 |=> st_q.en[4] == $past(pwdata[0])
            && st_q.mode[9:8] == $past(pwdata[5:4]))
        else $error("source four not set from low lane of second register");

    a_read_lane_a: assert property ( // see RULE6
        rd_done && paddr == WAKE_CFG_SRC0_3_ADDR
            |-> prdata[0] == st_q.en[0] && prdata[5:4] == st_q.mode[1:0])
        else $error("first register low lane reads wrong fields");

    a_reserved_zero: assert property ( // see RULE7
        rd_done && cfg_sel |-> (prdata & ~CFG_RD_MASK) == '0)
        else $error("reserved bits read nonzero");

    a_stop_wakes: assert property ( // see RULE1
        standby_mode == SWC_STOP && |(hits & ~SLEEP_ONLY_MASK) |=> wake_request)
        else $error("pin source failed to end stop");

    a_sleep_only: assert property ( // see RULE2
        standby_mode != SWC_SLEEP && !(|(hits & ~SLEEP_ONLY_MASK)) |=> !wake_request)
        else $error("sleep-only source ended another state");

    a_disabled_quiet: assert property ( // see RULE14
        st_q.en == '0 |-> ##2 !wake_request)
        else $error("wake request with every source disabled");

    a_ready_pulse: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready not a single cycle after one wait state");

    // bus answer: data, error flag and where pready may appear
    a_wr_data_zero: assert property (
        psel && penable && pready && pwrite |-> prdata == RDATA_IDLE)
        else $error("write returned nonzero read data");

    a_err_unmapped: assert property (
        psel && penable && pready |-> pslverr == !(cfg_sel || hit_sel))
        else $error("error flag disagrees with decode");

    a_status_no_err: assert property (
        wr_done && hit_sel |-> !pslverr)
        else $error("status write answered with error");

    a_ready_needs_acc: assert property (
        pready |-> $past(psel && penable))
        else $error("pready without an access cycle");

    a_reset_outputs: assert property (
        $rose(presetn) |-> !pready && !pslverr && !wake_request && prdata == RDATA_IDLE)
        else $error("outputs not idle after reset");

    // field placement seen from the bus, first two registers and status
    a_bad_write_kept: assert property ( // see RULE5
        wr_done && !cfg_sel |=> $stable(st_q.en) && $stable(st_q.mode))
        else $error("write outside config changed a field");

    a_write_src7: assert property ( // see RULE9
        wr_done && paddr == WAKE_CFG_SRC4_7_ADDR && pstrb[3]
            |=> st_q.en[7] == $past(pwdata[24])
            && st_q.mode[15:14] == $past(pwdata[29:28]))
        else $error("source seven not set from top lane");

    sequence s_read_a;
        rd_done && paddr == WAKE_CFG_SRC0_3_ADDR;
    endsequence

    a_read_lane_top: assert property ( // see RULE6
        s_read_a |-> prdata[24] == st_q.en[3] && prdata[29:28] == st_q.mode[7:6])
        else $error("first register top lane reads wrong");

    sequence s_read_b;
        rd_done && paddr == WAKE_CFG_SRC4_7_ADDR;
    endsequence

    a_read_grp_b: assert property ( // see RULE9
        s_read_b |-> prdata[8] == st_q.en[5] && prdata[13:12] == st_q.mode[11:10])
        else $error("second register lane one reads wrong");

    a_hit_high_zero: assert property (
        rd_done && hit_sel |-> prdata[31:NUM_SLOT-1] == '0)
        else $error("unused status bits not zero");

    // wake gating per state; a hit needs an enable one edge before it
    a_idle_wakes: assert property ( // see RULE1
        standby_mode == SWC_IDLE && |(hits & ~SLEEP_ONLY_MASK) |=> wake_request)
        else $error("pin source failed to end idle");

    a_sleep_chip: assert property ( // see RULE2
        standby_mode == SWC_SLEEP && (hits[SRC_RTC] || hits[SRC_QUAD]) |=> wake_request)
        else $error("on-chip source failed to end sleep");

    a_run_quiet: assert property (
        standby_mode == SWC_RUN |=> !wake_request)
        else $error("wake request while running");

    a_hit_needs_en: assert property ( // see RULE14
        (hits & ~$past(st_q.en)) == '0)
        else $error("hit from a disabled source");

endmodule

`default_nettype wire

/* File: verification/swc_pin_model.sv */
// partner model: wake pins and the standby clock controller
`timescale 1ns/1ps
`default_nettype none

module swc_pin_model
    import swc_pkg::*;
(
    input  wire logic    pclk,
    input  wire logic    presetn,
    input  wire logic    wake_request,
    output logic [11:0]  ext_irq,
    output logic [7:0]   key_wake_input,
    output logic         rtc_wake_irq,
    output logic         quad_counter_wake_irq,
    output swc_standby_t standby_mode
);
    swc_standby_t go_mode;
    logic         go;

    // =====================================================================
    // pins start quiet; the controller is asked into standby by the bench
    initial begin
        ext_irq = '0;
        key_wake_input = '0;
        rtc_wake_irq = 1'b0;
        quad_counter_wake_irq = 1'b0;
        go = 1'b0;
        go_mode = SWC_RUN;
    end

    // a wake request ends any standby at once, ahead of a new entry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_mode <= SWC_RUN;
        end else if (wake_request) begin
            standby_mode <= SWC_RUN;
        end else if (go) begin
            standby_mode <= go_mode;
        end
    end

    task automatic enter(input swc_standby_t m);
        @(posedge pclk);
        go_mode <= m;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
    endtask

    task automatic set_ext(input int i, input logic v);
        @(posedge pclk);
        ext_irq[i] <= v;
    endtask

    task automatic set_key(input int i, input logic v);
        @(posedge pclk);
        key_wake_input[i] <= v;
    endtask

    // one-cycle pulse on an on-chip source, rtc or quad counter
    task automatic pulse(input logic quad);
        @(posedge pclk);
        if (quad) begin
            quad_counter_wake_irq <= 1'b1;
        end else begin
            rtc_wake_irq <= 1'b1;
        end
        @(posedge pclk);
        quad_counter_wake_irq <= 1'b0;
        rtc_wake_irq <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the wake source configuration block
`timescale 1ns/1ps
`default_nettype none

module tb
    import swc_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_request;
    logic [31:0]  paddr, pwdata, prdata, rd;
    logic [3:0]   pstrb;
    logic [11:0]  ext_irq;
    logic [7:0]   key_wake_input;
    logic         rtc_wake_irq, quad_counter_wake_irq, er;
    swc_standby_t standby_mode;
    int           error_cnt, compares;

    swc_wake_cfg dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq(ext_irq),
        .key_wake_input(key_wake_input), .rtc_wake_irq(rtc_wake_irq),
        .quad_counter_wake_irq(quad_counter_wake_irq), .standby_mode(standby_mode),
        .wake_request(wake_request));

    swc_pin_model model_u (.pclk(pclk), .presetn(presetn), .wake_request(wake_request),
        .ext_irq(ext_irq), .key_wake_input(key_wake_input), .rtc_wake_irq(rtc_wake_irq),
        .quad_counter_wake_irq(quad_counter_wake_irq), .standby_mode(standby_mode));

    // =====================================================================
    // clock and reporting
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // =====================================================================
    // apb master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            $display("ERROR at %0t: no pready", $time);
            conclude();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // counts whether a wake request shows within a fixed window
    task automatic wake_in(input int n, input logic exp, input string what);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            if (wake_request === 1'b1) seen = 1'b1;
        end
        check({31'h0, seen}, {31'h0, exp}, what);
    endtask

    // one external source: settle the idle level, arm, then trigger
    task automatic ext_wake(input int idx, input swc_mode_t m, input swc_standby_t s);
        logic [31:0] a, cfg;
        a = WAKE_CFG_SRC0_3_ADDR + 32'(4 * (idx / 4));
        cfg = 32'h20202020;
        cfg[8 * (idx % 4) +: 8] = {2'h0, m, 3'h0, 1'b1};
        model_u.set_ext(idx, ~m[0]);
        repeat (8) @(posedge pclk);
        apb(1'b1, a, cfg, 4'hf, rd, er);
        model_u.enter(s);
        wake_in(10, 1'b0, "wake before trigger");
        model_u.set_ext(idx, m[0]);
        wake_in(12, 1'b1, "no wake on trigger");
        apb(1'b1, a, 32'h20202020, 4'hf, rd, er);
        model_u.set_ext(idx, 1'b0);
    endtask

    // on-chip source, rising edge, honoured only in sleep
    task automatic chip_wake(input logic quad, input swc_standby_t s, input logic exp);
        apb(1'b1, WAKE_CFG_AUX_ADDR, quad ? 32'h00312020 : 32'h00203120, 4'hf, rd, er);
        model_u.enter(s);
        model_u.pulse(quad);
        wake_in(8, exp, "on-chip wake");
        model_u.enter(SWC_RUN);
        apb(1'b1, WAKE_CFG_AUX_ADDR, 32'h00202020, 4'hf, rd, er);
    endtask

    // =====================================================================
    // main sequence
    initial begin
        error_cnt = 0;
        compares = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of the first three registers: falling edge mode, all disabled
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, WAKE_CFG_SRC0_3_ADDR + 32'(4 * i), '0, 4'hf, rd, er);
            check(rd, 32'h20202020, "reset value");
        end
        $display("test reset_values done");
        // writable fields only, lanes in source order
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, WAKE_CFG_SRC0_3_ADDR + 32'(4 * i), 32'hffffffff, 4'hf, rd, er);
            apb(1'b0, WAKE_CFG_SRC0_3_ADDR + 32'(4 * i), '0, 4'hf, rd, er);
            check(rd, 32'h31313131, "field mask");
        end
        apb(1'b1, WAKE_CFG_SRC4_7_ADDR, 32'h00000000, 4'h2, rd, er);
        apb(1'b0, WAKE_CFG_SRC4_7_ADDR, '0, 4'hf, rd, er);
        check(rd, 32'h31310031, "lane write");
        apb(1'b0, 32'hffffee24, '0, 4'hf, rd, er);
        check(rd, 32'h0, "unmapped read data");
        check({31'h0, er}, 32'h1, "unmapped read error");
        apb(1'b1, WAKE_CFG_SRC0_3_ADDR, 32'h20202020, 4'hf, rd, er);
        apb(1'b1, WAKE_CFG_SRC4_7_ADDR, 32'h20202020, 4'hf, rd, er);
        $display("test register_map done");
        // every mode code on source five in stop
        for (int m = 0; m < 4; m++) begin
            ext_wake(5, swc_mode_t'(m), SWC_STOP);
        end
        ext_wake(11, SWC_MODE_RISE, SWC_IDLE);
        ext_wake(0, SWC_MODE_LOW, SWC_SLEEP);
        $display("test ext_modes done");
        // disabled source stays silent, then wakes once enabled
        model_u.set_ext(3, 1'b1);
        apb(1'b1, WAKE_CFG_SRC0_3_ADDR, 32'h10202020, 4'hf, rd, er);
        model_u.enter(SWC_STOP);
        wake_in(15, 1'b0, "disabled source woke");
        apb(1'b1, WAKE_CFG_SRC0_3_ADDR, 32'h11202020, 4'hf, rd, er);
        wake_in(12, 1'b1, "enabled source idle");
        apb(1'b0, WAKE_HIT_ADDR, '0, 4'hf, rd, er);
        check(rd, 32'h00000008, "live hit status");
        apb(1'b1, WAKE_HIT_ADDR, 32'hffffffff, 4'hf, rd, er);
        check({31'h0, er}, 32'h0, "status write answered error");
        apb(1'b1, WAKE_CFG_SRC0_3_ADDR, 32'h20202020, 4'hf, rd, er);
        model_u.set_ext(3, 1'b0);
        $display("test enable_gate done");
        chip_wake(1'b0, SWC_STOP, 1'b0);
        chip_wake(1'b0, SWC_SLEEP, 1'b1);
        chip_wake(1'b1, SWC_IDLE, 1'b0);
        chip_wake(1'b1, SWC_SLEEP, 1'b1);
        $display("test onchip_sleep_only done");
        // key inputs share one slot, high level as software must set
        apb(1'b1, WAKE_CFG_AUX_ADDR, 32'h00202011, 4'hf, rd, er);
        model_u.enter(SWC_IDLE);
        model_u.set_key(7, 1'b1);
        wake_in(12, 1'b1, "key wake");
        apb(1'b1, WAKE_CFG_AUX_ADDR, 32'h00202020, 4'hf, rd, er);
        model_u.set_key(7, 1'b0);
        $display("test key_wake done");
        conclude();
    end
endmodule
`default_nettype wire
